// >>> hw/aofd_defs.svh
// Constants of the overrange fast detector: map, fields, resets.
// Assumes inclusion by bare name from every file that needs them.
`ifndef AOFD_DEFS_SVH
`define AOFD_DEFS_SVH
`define AOFD_ADDR_W 12
`define AOFD_DATA_W 8
`define AOFD_THR_W 13
`define AOFD_HI_W 5
`define AOFD_DWELL_W 16
`define AOFD_EVT_W 2
`define AOFD_A_CTRL 12'h245
`define AOFD_A_UP_LO 12'h247
`define AOFD_A_UP_HI 12'h248
`define AOFD_A_LO_LO 12'h249
`define AOFD_A_LO_HI 12'h24a
`define AOFD_A_DW_LO 12'h24b
`define AOFD_A_DW_HI 12'h24c
`define AOFD_A_STS 12'h24d
`define AOFD_A_MSK 12'h24e
`define AOFD_A_LIVE 12'h24f
`define AOFD_B_EN 0
`define AOFD_B_FVAL 2
`define AOFD_B_FORCE 3
`define AOFD_CTRL_WMASK 8'h0d
`define AOFD_HI_WMASK 8'h1f
`define AOFD_EVT_WMASK 8'h03
`define AOFD_RST_BYTE 8'h00
`define AOFD_RST_EVT 2'h0
`define AOFD_S_RISE 0
`define AOFD_S_FALL 1
`endif

// >>> hw/aofd_pkg.sv
// Types and shared helpers of the overrange fast detector.
// Assumes the constants header sits on the include path.
`include "aofd_defs.svh"
package aofd_pkg;
	typedef enum logic [0:0] {AOFD_IDLE = 1'b0, AOFD_HELD = 1'b1} aofd_det_t;
	typedef struct packed {
		aofd_det_t                det;
		logic [`AOFD_DWELL_W-1:0] cnt;
		logic                     rise;
		logic                     fall;
	} aofd_dwell_st_t;
	typedef struct packed {
		logic [`AOFD_DATA_W-1:0] ctrl, up_lo, up_hi, lo_lo, lo_hi, dw_lo, dw_hi;
		logic [`AOFD_EVT_W-1:0]  sts, msk;
		logic [`AOFD_DATA_W-1:0] rdata;
		logic                    pin;
		logic                    irq;
	} aofd_top_st_t;
	// Joins a low byte and the five upper bits into one threshold.
	function automatic logic [`AOFD_THR_W-1:0] aofd_join_thr(input logic [7:0] lo, input logic [7:0] hi);
		aofd_join_thr = {hi[`AOFD_HI_W-1:0], lo};
	endfunction
endpackage

// >>> hw/aofd_det_if.sv
// Bundle between the register file, the comparator and the dwell logic.
// Assumes all parties run on the one sample clock.
`timescale 1ns/1ns
`include "aofd_defs.svh"
interface aofd_det_if;
	logic [`AOFD_THR_W-1:0]   mag, upper, lower;
	logic                     above, below;
	logic [`AOFD_DWELL_W-1:0] target;
	logic                     enable;
	logic                     flag, rise, fall;
	modport cmp   (input mag, upper, lower, output above, below);
	modport dwell (input above, below, target, enable, output flag, rise, fall);
	modport ctl   (output mag, upper, lower, target, enable, input above, below, flag, rise, fall);
endinterface

// >>> hw/aofd_cmp.sv
// Magnitude comparator against the upper and lower thresholds.
// Assumes magnitude and thresholds are stable for the whole cycle.
`timescale 1ns/1ns
module aofd_cmp
	import aofd_pkg::*;
(
	aofd_det_if.cmp bus // Comparator side of the bundle.
);
	// Strict compares: equal to a threshold is neither over nor under.
	assign bus.above = (bus.mag > bus.upper);
	assign bus.below = (bus.mag < bus.lower);
endmodule

// >>> hw/aofd_dwell.sv
// Detector flag with dwell hold-off before it clears.
// Assumes one magnitude sample per clock and synchronous active-low reset.
`timescale 1ns/1ns
`include "aofd_defs.svh"
module aofd_dwell
	import aofd_pkg::*;
(
	input  wire logic  clk_sys_i, // Sample clock.
	input  wire logic  resetn_i,  // Synchronous reset, active low.
	aofd_det_if.dwell  bus        // Dwell side of the bundle.
);
	aofd_dwell_st_t s_ff;
	aofd_dwell_st_t nxt_s;
	logic [`AOFD_DWELL_W:0] cnt_inc;

	// Next state; the count is one bit wider so the last step cannot wrap.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.rise = 1'b0;
		nxt_s.fall = 1'b0;
		cnt_inc = {1'b0, s_ff.cnt} + {{`AOFD_DWELL_W{1'b0}}, 1'b1};
		if (!bus.enable) begin
			nxt_s.det = AOFD_IDLE;
			nxt_s.cnt = '0;
		end else begin
			case (s_ff.det)
				AOFD_IDLE: begin
					if (bus.above) begin
						nxt_s.det = AOFD_HELD;
						nxt_s.cnt = '0;
						nxt_s.rise = 1'b1;
					end
				end
				AOFD_HELD: begin
					if (!bus.below) begin
						nxt_s.cnt = '0;
					end else if (cnt_inc >= {1'b0, bus.target}) begin
						nxt_s.det = AOFD_IDLE;
						nxt_s.cnt = '0;
						nxt_s.fall = 1'b1;
					end else begin
						nxt_s.cnt = cnt_inc[`AOFD_DWELL_W-1:0];
					end
				end
				default: begin
					nxt_s.det = AOFD_IDLE;
					nxt_s.cnt = '0;
				end
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_ff <= '{det: AOFD_IDLE, cnt: '0, rise: 1'b0, fall: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign bus.flag = (s_ff.det == AOFD_HELD);
	assign bus.rise = s_ff.rise;
	assign bus.fall = s_ff.fall;
endmodule

// >>> hw/aofd_top.sv
// Overrange fast detector for one converter channel.
// Holds the byte-wide control, threshold and dwell registers,
// the comparator and dwell logic, the flag pin and an interrupt.
// Assumes one magnitude sample per clock on clk_sys_i, inputs
// synchronous to that clock, and a master that never issues a
// read and a write strobe in the same cycle.
`timescale 1ns/1ns
`include "aofd_defs.svh"

//
// Contract
// - Control bit 3 low drives pin from detector; high forces it.
// - While forced, pin follows control bit 2.
// - Compare magnitude with 13-bit upper threshold split over two addresses.
// - Hold 13-bit lower threshold split over two addresses, also compared.
// - 16-bit dwell counter compared with a target in two byte registers.
// - While enabled, flag clears only after magnitude stays below lower for target samples.
module aofd_top
	import aofd_pkg::*;
(
	input  wire logic                    clk_sys_i,            // Sample clock, 25 MHz.
	input  wire logic                    resetn_i,             // Synchronous reset, active low.
	input  wire logic [`AOFD_THR_W-1:0]  mag_i,                // Fine converter magnitude.
	input  wire logic [`AOFD_ADDR_W-1:0] addr_i,               // Register address.
	input  wire logic [`AOFD_DATA_W-1:0] wdata_i,              // Register write data.
	input  wire logic                    wr_i,                 // Write strobe, one cycle.
	input  wire logic                    rd_i,                 // Read strobe, one cycle.
	output logic      [`AOFD_DATA_W-1:0] rdata_o,              // Read data, cycle after rd_i.
	output logic                         overrange_flag_pin_o, // Flag pin to gain control.
	output logic                         irq_o                 // Level interrupt, active high.
);

	// Register state and its next value.
	aofd_top_st_t s_ff;
	aofd_top_st_t nxt_s;

	// Decoded strobes and event vector.
	logic                   wr_ctrl;
	logic                   wr_msk;
	logic                   rd_sts;
	logic [`AOFD_EVT_W-1:0] evt;

	// Bundle shared with the comparator and the dwell logic.
	aofd_det_if det_bus ();

	// Masks a written byte down to its implemented bits.
	function automatic logic [7:0] keep_bits(input logic [7:0] d, input logic [7:0] m);
		keep_bits = d & m;
	endfunction

	// Read multiplexer; unmapped addresses read as zero.
	function automatic logic [7:0] read_mux(
		input logic [`AOFD_ADDR_W-1:0] a,
		input aofd_top_st_t            s,
		input logic                    flag
	);
		read_mux = `AOFD_RST_BYTE;
		case (a)
			`AOFD_A_CTRL: begin
				read_mux = s.ctrl;
			end
			`AOFD_A_UP_LO: begin
				read_mux = s.up_lo;
			end
			`AOFD_A_UP_HI: begin
				read_mux = s.up_hi;
			end
			`AOFD_A_LO_LO: begin
				read_mux = s.lo_lo;
			end
			`AOFD_A_LO_HI: begin
				read_mux = s.lo_hi;
			end
			`AOFD_A_DW_LO: begin
				read_mux = s.dw_lo;
			end
			`AOFD_A_DW_HI: begin
				read_mux = s.dw_hi;
			end
			`AOFD_A_STS: begin
				read_mux = {{(`AOFD_DATA_W-`AOFD_EVT_W){1'b0}}, s.sts};
			end
			`AOFD_A_MSK: begin
				read_mux = {{(`AOFD_DATA_W-`AOFD_EVT_W){1'b0}}, s.msk};
			end
			`AOFD_A_LIVE: begin
				read_mux = {6'h00, s.pin, flag};
			end
			default: begin
				read_mux = `AOFD_RST_BYTE;
			end
		endcase
	endfunction

	// Feed the bundle from the threshold and dwell registers.
	// The split halves are joined here so a half-written threshold
	// is visible until the other half is written; software should write the low byte
	// first while the detector is disabled if that matters.
	assign det_bus.mag    = mag_i;
	assign det_bus.upper  = aofd_join_thr(s_ff.up_lo, s_ff.up_hi);
	assign det_bus.lower  = aofd_join_thr(s_ff.lo_lo, s_ff.lo_hi);
	assign det_bus.target = {s_ff.dw_hi, s_ff.dw_lo};
	assign det_bus.enable = s_ff.ctrl[`AOFD_B_EN];

	// Comparator of magnitude against both thresholds.
	aofd_cmp u_cmp (
		.bus (det_bus.cmp)
	);

	// Flag state machine with dwell hold-off.
	aofd_dwell u_dwell (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.bus       (det_bus.dwell)
	);

	// Strobe decode for the registers with side effects.
	assign wr_ctrl = wr_i && (addr_i == `AOFD_A_CTRL);
	assign wr_msk  = wr_i && (addr_i == `AOFD_A_MSK);
	assign rd_sts  = rd_i && (addr_i == `AOFD_A_STS);

	// Flag edges are the interrupt sources.
	assign evt[`AOFD_S_RISE] = det_bus.rise;
	assign evt[`AOFD_S_FALL] = det_bus.fall;

	// Next state of every register.
	always_comb begin
		nxt_s = s_ff;

		// Plain writes; reserved bits are dropped so they read zero.
		if (wr_ctrl) begin
			nxt_s.ctrl = keep_bits(wdata_i, `AOFD_CTRL_WMASK);
		end
		if (wr_i) begin
			case (addr_i)
				`AOFD_A_UP_LO: begin
					nxt_s.up_lo = wdata_i;
				end
				`AOFD_A_UP_HI: begin
					nxt_s.up_hi = keep_bits(wdata_i, `AOFD_HI_WMASK);
				end
				`AOFD_A_LO_LO: begin
					nxt_s.lo_lo = wdata_i;
				end
				`AOFD_A_LO_HI: begin
					nxt_s.lo_hi = keep_bits(wdata_i, `AOFD_HI_WMASK);
				end
				`AOFD_A_DW_LO: begin
					nxt_s.dw_lo = wdata_i;
				end
				`AOFD_A_DW_HI: begin
					nxt_s.dw_hi = wdata_i;
				end
				default: begin
					nxt_s.dw_hi = s_ff.dw_hi;
				end
			endcase
		end
		if (wr_msk) begin
			nxt_s.msk = wdata_i[`AOFD_EVT_W-1:0];
		end

		// Reading status clears it, but a new event in the same
		// cycle survives, so no edge is ever lost to the read.
		if (rd_sts) begin
			nxt_s.sts = evt;
		end else begin
			nxt_s.sts = s_ff.sts | evt;
		end

		// Read data exists only in the cycle after the strobe.
		if (rd_i) begin
			nxt_s.rdata = read_mux(addr_i, s_ff, det_bus.flag);
		end else begin
			nxt_s.rdata = `AOFD_RST_BYTE;
		end

		// Pin source: forced level or the enabled detector flag.
		// The enable gate covers the one cycle in which the dwell
		// logic has not yet seen a disable.
		if (s_ff.ctrl[`AOFD_B_FORCE]) begin
			nxt_s.pin = s_ff.ctrl[`AOFD_B_FVAL];
		end else begin
			nxt_s.pin = det_bus.flag & s_ff.ctrl[`AOFD_B_EN];
		end

		// Interrupt follows the next status so a cleared source
		// drops the line in the same edge as the clear.
		nxt_s.irq = |(nxt_s.sts & nxt_s.msk);
	end

	// Single register stage for all state.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			s_ff <= '{ctrl: `AOFD_RST_BYTE, up_lo: `AOFD_RST_BYTE,
				up_hi: `AOFD_RST_BYTE, lo_lo: `AOFD_RST_BYTE,
				lo_hi: `AOFD_RST_BYTE, dw_lo: `AOFD_RST_BYTE,
				dw_hi: `AOFD_RST_BYTE, sts: `AOFD_RST_EVT,
				msk: `AOFD_RST_EVT, rdata: `AOFD_RST_BYTE,
				pin: 1'b0, irq: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state register.
	assign rdata_o              = s_ff.rdata;
	assign overrange_flag_pin_o = s_ff.pin;
	assign irq_o                = s_ff.irq;

endmodule

// >>> verif/aofd_top_asserts.sv
// Port checker of the overrange detector top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "aofd_defs.svh"
module aofd_top_asserts
	import aofd_pkg::*;
(
	input wire logic        clk_sys_i,            // Clock.
	input wire logic        resetn_i,             // Reset.
	input wire logic [12:0] mag_i,                // Magnitude.
	input wire logic [11:0] addr_i,               // Address.
	input wire logic [7:0]  wdata_i,              // Write data.
	input wire logic        wr_i,                 // Write.
	input wire logic        rd_i,                 // Read.
	input wire logic [7:0]  rdata_o,              // Read data.
	input wire logic        overrange_flag_pin_o, // Pin.
	input wire logic        irq_o                 // Interrupt.
);
	localparam logic [7:0] WM [10] = '{8'h0d, 8'h00, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'h00, 8'h03};
	logic [7:0]  sh_ff [10]; // Shadow registers.
	logic [31:0] run_ff;     // Run of low samples.
	logic [3:0]  ix;
	logic        ok;
	wire         map = addr_i >= `AOFD_A_CTRL && addr_i <= `AOFD_A_MSK;
	assign ix = 4'(addr_i - `AOFD_A_CTRL);
	assign ok = sh_ff[0][0] & ~sh_ff[0][3];
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// Shadow the writes; status has no write bits, so it stays zero.
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			sh_ff  <= '{default: 8'h00};
			run_ff <= 32'h0;
		end else begin
			if (wr_i && map)
				sh_ff[ix] <= wdata_i & WM[ix];
			run_ff <= (sh_ff[0][0] && mag_i < {sh_ff[5][4:0], sh_ff[4]}) ? run_ff + 32'h1 : 32'h0;
		end
	end
	sequence s_hit;
		ok && mag_i > {sh_ff[3][4:0], sh_ff[2]} && mag_i >= {sh_ff[5][4:0], sh_ff[4]} ##1 ok;
	endsequence
	property p_rise;
		s_hit |=> overrange_flag_pin_o;
	endproperty
	a_rise: assert property (p_rise) else $error("pin missed rise");
	property p_force;
		sh_ff[0][3] |=> overrange_flag_pin_o == $past(sh_ff[0][2]);
	endproperty
	a_force: assert property (p_force) else $error("pin not forced");
	property p_off;
		!sh_ff[0][0] && !sh_ff[0][3] |=> !overrange_flag_pin_o;
	endproperty
	a_off: assert property (p_off) else $error("pin high while off");
	property p_fall;
		$fell(overrange_flag_pin_o) && $past(ok) && $past(ok, 2) |-> $past(run_ff) >= 32'h1
			&& $past(run_ff) >= 32'({$past(sh_ff[7], 2), $past(sh_ff[6], 2)});
	endproperty
	a_fall: assert property (p_fall) else $error("pin fell early");
	property p_rd;
		rd_i && map && ix != 4'h8 |=> rdata_o == $past(sh_ff[ix]);
	endproperty
	a_rd: assert property (p_rd) else $error("bad read data");
	property p_quiet;
		!rd_i || addr_i < `AOFD_A_CTRL || addr_i > `AOFD_A_LIVE |=> rdata_o == 8'h00;
	endproperty
	a_quiet: assert property (p_quiet) else $error("read data not zero");
	property p_live;
		rd_i && addr_i == `AOFD_A_LIVE |=> rdata_o[1] == $past(overrange_flag_pin_o) && rdata_o[7:2] == 6'h00;
	endproperty
	a_live: assert property (p_live) else $error("live pin bad");
	property p_irq;
		irq_o |-> (sh_ff[9] | $past(sh_ff[9])) != 8'h00;
	endproperty
	a_irq: assert property (p_irq) else $error("irq while masked");
endmodule
bind aofd_top aofd_top_asserts u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mag_i(mag_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.overrange_flag_pin_o(overrange_flag_pin_o), .irq_o(irq_o));

// >>> verif/aofd_agc_mon.sv
// Gain-control watcher counting flag pin rises.
// Assumes a registered pin on the sample clock.
`timescale 1ns/1ns
module aofd_agc_mon (
	input  wire logic clk_sys_i, // Clock.
	input  wire logic pin_i,     // Pin level.
	output int        rises_o    // Rises seen.
);
	logic last_ff = 1'b0;
	initial rises_o = 0;
	// Gain backs off once per overrange episode, so only rises count.
	always @(posedge clk_sys_i) begin
		if (pin_i === 1'b1 && last_ff !== 1'b1)
			rises_o <= rises_o + 1;
		last_ff <= pin_i;
	end
endmodule

// >>> verif/tb_aofd_top.sv
// Self-checking bench of the overrange detector.
// Assumes design, checker and watcher compiled first.
`timescale 1ns/1ns
module tb_aofd_top
	import aofd_pkg::*;
;
	logic        clk_sys_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [12:0] mag_i = 13'h0000;
	logic [11:0] addr_i = 12'h000;
	logic [7:0]  wdata_i = 8'h00;
	wire  [7:0]  rdata_o;
	wire         flag_pin, irq_o;
	int          err_count = 0, checked = 0, cyc = 0, rises, pr = 0, base = 0, span = 40;
	int          r [11], wm [11] = '{'h0d, 0, 'hff, 'h1f, 'hff, 'h1f, 'hff, 'hff, 0, 3, 0};
	int          fl, n, rp, fp, sts, pe, irq_m, ro, i, idx;
	int          cfg [8] = '{'h24501, 'h2471e, 'h24800, 'h2490a, 'h24a00, 'h24b03, 'h24c00, 'h24e03};
	int          md [8] = '{'h0c, 'h08, 'h0d, 'h09, 'h00, 'h05, 'h01, 'h04};
	aofd_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .mag_i(mag_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.overrange_flag_pin_o(flag_pin), .irq_o(irq_o));
	aofd_agc_mon u_agc (.clk_sys_i(clk_sys_i), .pin_i(flag_pin), .rises_o(rises));
	initial forever #20 clk_sys_i = ~clk_sys_i;
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wr(input int a, input int d);
		@(posedge clk_sys_i);
		addr_i  <= 12'(a);
		wdata_i <= 8'(d);
		wr_i    <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	// Random magnitudes with random reads over the map and its edges.
	task automatic run(input int cnt);
		repeat (cnt) begin
			@(posedge clk_sys_i);
			mag_i  <= 13'(base + $urandom % span);
			rd_i   <= ($urandom % 6) == 0;
			addr_i <= 12'h244 + 12'($urandom % 13);
		end
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
	endtask
	// Reference model; every term uses values sampled at this edge.
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 5000) begin
			err_count++;
			report_and_stop();
		end
		idx = int'(addr_i) - 'h245;
		if (!resetn_i) begin
			foreach (r[k]) r[k] = 0;
			{fl, n, rp, fp, sts, pe, irq_m, ro} = 0;
		end else begin
			ro = (rd_i && idx >= 0 && idx <= 9) ? (idx == 8 ? sts : r[idx]) : 0;
			if (rd_i && idx == 10)
				ro = pe * 2 + fl;
			sts = ((rd_i && idx == 8) ? 0 : sts) | rp | fp * 2;
			i = r[0][3] ? r[0][2] : r[0][0] & fl;
			pr += i && !pe;
			pe = i;
			{rp, fp} = 0;
			// While held, a below sample counts even when it is also above.
			if (!r[0][0])
				{fl, n} = 0;
			else if (!fl && mag_i > {r[3][4:0], r[2][7:0]}) begin
				rp = !fl;
				{fl, n} = {32'd1, 32'd0};
			end else if (fl && mag_i < {r[5][4:0], r[4][7:0]}) begin
				n++;
				if (n >= {r[7][7:0], r[6][7:0]}) begin
					{fl, n} = 0;
					fp = 1;
				end
			end else
				n = 0;
			if (wr_i && idx >= 0 && idx <= 9)
				r[idx] = wdata_i & wm[idx];
			irq_m = (sts & r[9]) != 0;
		end
	end
	// Outputs are settled at the falling edge.
	always @(negedge clk_sys_i) if (cyc > 0) begin
		chk("pin", flag_pin, 16'(pe));
		chk("irq", irq_o, 16'(irq_m));
		chk("rdata", rdata_o, 16'(ro));
	end
	initial begin
		void'($urandom(98));
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		run(20);
		for (int a = 'h244; a <= 'h250; a++) wr(a, $urandom);
		run(30);
		$display("test 1 done");
		foreach (cfg[k]) wr(cfg[k] >> 8, cfg[k] & 'hff);
		run(400);
		$display("test 2 done");
		foreach (md[k]) begin
			wr('h245, md[k]);
			run(25);
		end
		$display("test 3 done");
		foreach (cfg[k]) wr(cfg[k] >> 8, cfg[k] & 'hff);
		wr('h24c, 1); // Target 0x0103 needs the high byte.
		wr('h248, 1);
		wr('h24a, 1);
		wr('h24e, 1);
		base = 300;
		span = 50;
		run(5);
		base = 0;
		span = 266;
		run(300);
		$display("test 4 done");
		@(posedge clk_sys_i);
		resetn_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		run(20);
		wr('h245, 0);
		repeat (3) @(posedge clk_sys_i);
		chk("agc rises", 16'(rises), 16'(pr));
		$display("test 5 done");
		report_and_stop();
	end
endmodule
